// File: design/tcp_timer.sv
// Top of one timer/counter/PWM unit with its counter, comparator, capture and interrupt.
// Assumes routed inputs are asynchronous; configuration ports are static system-clock levels.
`timescale 1ns/1ns
`default_nettype none
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int unsigned W   = CNT_W,
  parameter int unsigned NSRC = NUM_CLK_SRC,
  parameter int unsigned DBW = DB_W
) (
  // Clock and reset.
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_in,
  // Clock source selection.
  input  wire logic [NSRC-1:0]      clk_src_in,
  input  wire logic [SRC_SEL_W-1:0] clk_sel_in,
  // Configuration.
  input  wire logic [1:0]           mode_in,
  input  wire logic [2:0]           cmp_mode_in,
  input  wire logic [W-1:0]         period_in,
  input  wire logic [W-1:0]         compare_in,
  input  wire logic [DBW-1:0]       dead_ticks_in,
  input  wire logic                 irq_tc_en_in,
  input  wire logic                 irq_cmp_en_in,
  input  wire logic                 irq_cap_en_in,
  // Software controls.
  input  wire logic                 sw_start_in,
  input  wire logic                 sw_stop_in,
  input  wire logic                 cnt_read_in,
  // Routed inputs.
  input  wire logic                 start_in,
  input  wire logic                 treset_in,
  input  wire logic                 capture_in,
  input  wire logic                 enable_in,
  input  wire logic                 kill_in,
  // Routed outputs.
  output logic                      cmp_out,
  output logic                      cmp_n_out,
  output logic                      tc_out,
  output logic                      irq_out,
  // Status.
  output logic [W-1:0]              count_out,
  output logic [W-1:0]              capture_out,
  output logic                      running_out
);
  // Synchronised pins: sources, start, reset, capture, enable, kill.
  localparam int unsigned NSYN = NSRC + 5;
  logic [NSYN-1:0] syn;
  logic [NSRC-1:0] src_s;
  logic            start_s;
  logic            trst_s;
  logic            cap_s;
  logic            en_s;
  logic            kill_s;

  tcp_sync #(.WIDTH(NSYN)) u_sync (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   ({kill_in, enable_in, capture_in, treset_in, start_in, clk_src_in}),
    .sync_out   (syn)
  );
  assign src_s   = syn[NSRC-1:0];
  assign start_s = syn[NSRC];
  assign trst_s  = syn[NSRC+1];
  assign cap_s   = syn[NSRC+2];
  assign en_s    = syn[NSRC+3];
  assign kill_s  = syn[NSRC+4];

  tcp_run_e        state_reg;
  tcp_run_e        state_next;
  logic [W-1:0]    cnt_reg;
  logic [W-1:0]    cnt_next;
  logic [W-1:0]    cap_reg;
  logic [W-1:0]    cap_next;
  logic [W-1:0]    rd_reg;
  logic [W-1:0]    rd_next;
  logic            src_d_reg;
  logic            trst_d_reg;
  logic            cap_d_reg;
  logic            start_d_reg;
  logic            tc_reg;
  logic            tc_next;
  logic            cmp_reg;
  logic            cmp_next;
  logic            irq_reg;
  logic            irq_next;
  logic            sel_src;
  logic            tick;
  logic            trst_rise;
  logic            cap_rise;
  logic            start_rise;
  logic            cmp_raw;
  logic            counting;
  logic            at_zero;

  // Pick the chosen source and turn its rising edge into a one-cycle tick.
  always_comb begin
    sel_src = src_s[clk_sel_in];
  end
  assign tick       = sel_src & ~src_d_reg;
  assign trst_rise  = trst_s & ~trst_d_reg;
  assign cap_rise   = cap_s & ~cap_d_reg;
  assign start_rise = (start_s & ~start_d_reg) | sw_start_in;

  // Comparator with selectable relation.
  always_comb begin
    case (cmp_mode_in)
      CMP_LT:  cmp_raw = cnt_reg <  compare_in;
      CMP_LTE: cmp_raw = cnt_reg <= compare_in;
      CMP_EQ:  cmp_raw = cnt_reg == compare_in;
      CMP_GTE: cmp_raw = cnt_reg >= compare_in;
      CMP_GT:  cmp_raw = cnt_reg >  compare_in;
      default: cmp_raw = 1'b0;
    endcase
  end

  assign at_zero  = (cnt_reg == CNT_RESET[W-1:0]);
  // Gated mode advances only on ticks with enable high.
  assign counting = (state_reg == TCP_RUN) && tick &&
                    ((mode_in != MODE_GATED) || en_s);

  // Counter, run state, terminal count, capture and interrupt next values.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cap_next   = cap_reg;
    rd_next    = rd_reg;
    tc_next    = 1'b0;
    cmp_next   = cmp_raw;
    irq_next   = 1'b0;
    case (state_reg)
      TCP_IDLE: begin
        if (start_rise) begin
          state_next = TCP_RUN;
          cnt_next   = period_in;
        end
      end
      TCP_RUN: begin
        if (sw_stop_in) begin
          state_next = TCP_IDLE;
        end else if (trst_rise) begin
          cnt_next = period_in;
        end else if (counting) begin
          if (at_zero) begin
            tc_next  = 1'b1;
            cnt_next = period_in;
            if (mode_in == MODE_ONESHOT) begin
              state_next = TCP_IDLE;
            end
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
      end
      default: state_next = TCP_IDLE;
    endcase
    if (cap_rise) begin
      cap_next = cnt_reg;
    end
    // Read latch keeps a whole-word snapshot; the count itself is untouched.
    if (cnt_read_in) begin
      rd_next = cnt_reg;
    end
    irq_next = (irq_tc_en_in & tc_next) |
               (irq_cmp_en_in & cmp_raw & ~cmp_reg) |
               (irq_cap_en_in & cap_rise);
  end

  // Registers of the counter unit.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg   <= TCP_IDLE;
      cnt_reg     <= CNT_RESET[W-1:0];
      cap_reg     <= CAP_RESET[W-1:0];
      rd_reg      <= CNT_RESET[W-1:0];
      src_d_reg   <= 1'b0;
      trst_d_reg  <= 1'b0;
      cap_d_reg   <= 1'b0;
      start_d_reg <= 1'b0;
      tc_reg      <= 1'b0;
      cmp_reg     <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      cap_reg     <= cap_next;
      rd_reg      <= rd_next;
      src_d_reg   <= sel_src;
      trst_d_reg  <= trst_s;
      cap_d_reg   <= cap_s;
      start_d_reg <= start_s;
      tc_reg      <= tc_next;
      cmp_reg     <= cmp_next;
      irq_reg     <= irq_next;
    end
  end

  // Complementary dead-banded pair with kill.
  tcp_deadband #(.DBW(DBW)) u_db (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .tick_in       (tick),
    .pwm_in        (cmp_reg),
    .kill_in       (kill_s),
    .dead_ticks_in (dead_ticks_in),
    .true_out      (cmp_out),
    .comp_out      (cmp_n_out)
  );

  assign tc_out      = tc_reg;
  assign irq_out     = irq_reg;
  assign count_out   = rd_reg;
  assign capture_out = cap_reg;
  assign running_out = (state_reg == TCP_RUN);

  down_only_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_reg == TCP_RUN && counting && !at_zero && !trst_rise && !sw_stop_in)
      |=> cnt_reg == $past(cnt_reg) - 1'b1) else $error("counter did not step down by one");
  tc_reload_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    tc_reg |-> (cnt_reg == $past(period_in))) else $error("no period reload at terminal count");
  tc_single_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    tc_reg |=> !tc_reg) else $error("terminal count wider than one cycle");
  start_load_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_reg == TCP_IDLE && start_rise) |=> (cnt_reg == $past(period_in) && running_out))
    else $error("start did not load period");
  treset_load_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_reg == TCP_RUN && trst_rise && !sw_stop_in) |=> cnt_reg == $past(period_in))
    else $error("timer reset did not reload period");
  capture_latch_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    cap_rise |=> capture_out == $past(cnt_reg)) else $error("capture value wrong");
  oneshot_stop_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (mode_in == MODE_ONESHOT && tc_reg) |-> !running_out) else $error("one-shot kept running");
  freerun_keep_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (mode_in == MODE_FREE && tc_reg && !$past(sw_stop_in)) |-> running_out)
    else $error("free-run stopped at terminal count");
  gated_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (mode_in == MODE_GATED && !en_s && !trst_rise && !start_rise) |=> $stable(cnt_reg))
    else $error("gated counter moved without enable");
  read_snap_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    cnt_read_in |=> count_out == $past(cnt_reg)) else $error("read snapshot wrong");
  irq_tc_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (tc_reg && irq_tc_en_in) |-> irq_out) else $error("terminal-count interrupt missing");
endmodule : tcp_timer
`default_nettype wire

// File: design/tcp_pkg.sv
// Constants and types for the timer/counter/PWM unit.
// Assumes a single 20 MHz system clock and synchronous active-high reset.
package tcp_pkg;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned DB_W         = 8;
  localparam int unsigned NUM_CLK_SRC  = 4;
  localparam int unsigned SRC_SEL_W    = 2;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [15:0] CAP_RESET    = 16'h0000;
  localparam logic [7:0]  DB_ZERO      = 8'h00;
  // Comparator relation codes.
  localparam logic [2:0]  CMP_LT       = 3'h0;
  localparam logic [2:0]  CMP_LTE      = 3'h1;
  localparam logic [2:0]  CMP_EQ       = 3'h2;
  localparam logic [2:0]  CMP_GTE      = 3'h3;
  localparam logic [2:0]  CMP_GT       = 3'h4;
  // Run mode codes.
  localparam logic [1:0]  MODE_FREE    = 2'h0;
  localparam logic [1:0]  MODE_ONESHOT = 2'h1;
  localparam logic [1:0]  MODE_GATED   = 2'h2;
  typedef enum logic [1:0] {TCP_IDLE, TCP_RUN} tcp_run_e;
endpackage : tcp_pkg

// File: design/tcp_sync.sv
// Two-flip-flop synchroniser bank for inputs arriving from pins or routing.
// Assumes the inputs are asynchronous levels; output lags by two clocks.
`timescale 1ns/1ns
`default_nettype none
module tcp_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  // Data.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Next values: first stage samples the pin, second stage reads only the first.
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Registers of the two stages.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : tcp_sync
`default_nettype wire

// File: design/tcp_deadband.sv
// Dead-band generator producing a non-overlapping true/complement pair.
// Assumes pwm_in and tick_in are on the system clock; kill_in is synchronised.
`timescale 1ns/1ns
`default_nettype none
module tcp_deadband
  import tcp_pkg::*;
#(
  parameter int unsigned DBW = DB_W
) (
  // Clock and reset.
  input  wire logic           clk_sys_in,
  input  wire logic           reset_in,
  // Control.
  input  wire logic           tick_in,
  input  wire logic           pwm_in,
  input  wire logic           kill_in,
  input  wire logic [DBW-1:0] dead_ticks_in,
  // Outputs.
  output logic                true_out,
  output logic                comp_out
);
  logic           last_reg;
  logic           last_next;
  logic [DBW-1:0] wait_reg;
  logic [DBW-1:0] wait_next;
  logic           t_reg;
  logic           t_next;
  logic           c_reg;
  logic           c_next;

  // On each change of the PWM level both outputs drop, then the new one rises after the delay.
  always_comb begin
    last_next = last_reg;
    wait_next = wait_reg;
    t_next    = t_reg;
    c_next    = c_reg;
    if (pwm_in != last_reg) begin
      last_next = pwm_in;
      t_next    = 1'b0;
      c_next    = 1'b0;
      wait_next = dead_ticks_in;
    end else if (tick_in) begin
      if (wait_reg != DB_ZERO[DBW-1:0]) begin
        wait_next = wait_reg - 1'b1;
      end else begin
        t_next = last_reg;
        c_next = ~last_reg;
      end
    end
    if (kill_in) begin
      t_next = 1'b0;
      c_next = 1'b0;
    end
  end

  // Registers of the dead-band stage.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      last_reg <= 1'b0;
      wait_reg <= DB_ZERO[DBW-1:0];
      t_reg    <= 1'b0;
      c_reg    <= 1'b0;
    end else begin
      last_reg <= last_next;
      wait_reg <= wait_next;
      t_reg    <= t_next;
      c_reg    <= c_next;
    end
  end

  assign true_out = t_reg;
  assign comp_out = c_reg;

  never_overlap_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !(t_reg && c_reg)) else $error("true and complement outputs active together");
  kill_forces_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    kill_in |=> (!t_reg && !c_reg)) else $error("outputs active after kill");
endmodule : tcp_deadband
`default_nettype wire

// File: tb/tcp_fabric_model.sv
// Routing-fabric model: free-running clock sources and routed event and level pins.
// Assumes tasks are called from the falling edge of the system clock.
`timescale 1ns/1ns
`default_nettype none
module tcp_fabric_model (
  // Clock.
  input  wire logic  clk_sys_in,
  // Routed signals toward the timer.
  output logic [3:0] clk_src_out,
  output logic       start_out,
  output logic       treset_out,
  output logic       capture_out,
  output logic       enable_out,
  output logic       kill_out
);
  logic [2:0]  ev;
  int unsigned div_cnt [4];
  // Event pins come from one vector so a pulse task can address them by index.
  assign start_out   = ev[0];
  assign treset_out  = ev[1];
  assign capture_out = ev[2];
  // Sources have half periods of 3 to 6 cycles, so each phase outlasts the synchroniser.
  initial begin
    clk_src_out = 4'h0;
    ev          = 3'h0;
    enable_out  = 1'b0;
    kill_out    = 1'b0;
  end
  // Toggles each source when its half period has run out.
  always @(negedge clk_sys_in) begin
    for (int i = 0; i < 4; i++) begin
      if (div_cnt[i] == i + 2) begin
        clk_src_out[i] = ~clk_src_out[i];
        div_cnt[i]     = 0;
      end else begin
        div_cnt[i]++;
      end
    end
  end
  // Holds one event pin high for four cycles so exactly one rise is seen.
  task automatic pulse_pin(input int k);
    ev[k] = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    ev[k] = 1'b0;
  endtask : pulse_pin
endmodule : tcp_fabric_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for one timer/counter/PWM unit.
// Assumes the fabric model supplies clock sources and routed pins.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tcp_pkg::*;
  typedef struct {logic chk; logic [16:0] ticks; logic run; logic irq;} tcp_note_s;
  logic        clk_sys_in, reset_in, src_q;
  logic [3:0]  clk_src;
  logic [1:0]  clk_sel, mode;
  logic [2:0]  cmp_mode;
  logic [15:0] period, compare, count, cap, c1, v;
  logic [7:0]  dead;
  logic        tc_en, cmp_en, cap_en, sw_start, sw_stop, rd, start, trst, capt, en, kill;
  logic        cmp, cmp_n, tc, irq, running, exp_c, prev_c;
  int          mismatches, checks_done, irq_seen, ticks, i0;
  tcp_note_s   notes [$];
  tcp_timer tcp_timer_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_src_in(clk_src),
    .clk_sel_in(clk_sel), .mode_in(mode), .cmp_mode_in(cmp_mode),
    .period_in(period), .compare_in(compare), .dead_ticks_in(dead),
    .irq_tc_en_in(tc_en), .irq_cmp_en_in(cmp_en), .irq_cap_en_in(cap_en),
    .sw_start_in(sw_start), .sw_stop_in(sw_stop), .cnt_read_in(rd),
    .start_in(start), .treset_in(trst), .capture_in(capt), .enable_in(en),
    .kill_in(kill), .cmp_out(cmp), .cmp_n_out(cmp_n), .tc_out(tc), .irq_out(irq),
    .count_out(count), .capture_out(cap), .running_out(running));
  tcp_fabric_model fabric_inst (
    .clk_sys_in(clk_sys_in), .clk_src_out(clk_src), .start_out(start),
    .treset_out(trst), .capture_out(capt), .enable_out(en), .kill_out(kill));
  // System clock of 50 ns period.
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc
  // Pulses one software control for a single cycle: 0 start, 1 stop, 2 read.
  task automatic sw(input int k);
    {rd, sw_stop, sw_start} = 3'b001 << k;
    cyc(1);
    {rd, sw_stop, sw_start} = 3'b000;
    cyc(1);
  endtask : sw
  task automatic rd_cnt(output logic [15:0] val);
    sw(2);
    cyc(2);
    val = count;
  endtask : rd_cnt
  // Waits, with a bound, until every expected terminal count has been seen.
  task automatic wait_q();
    for (int i = 0; i < 3000; i++) begin
      if (notes.size() == 0) return;
      cyc(1);
    end
    chk("pending tc", 0, notes.size());
    conclude();
  endtask : wait_q
  // Cuts a hang short.
  initial begin
    #4000000;
    chk("watchdog", 0, 1);
    conclude();
  end
  // Takes the oldest note at each terminal count and watches the output pair.
  always @(posedge clk_sys_in) begin
    tcp_note_s n;
    src_q <= clk_src[clk_sel];
    if (clk_src[clk_sel] && !src_q) ticks++;
    if (irq === 1'b1) irq_seen++;
    if (cmp === 1'b1 && cmp_n === 1'b1) chk("overlap", 0, 1);
    if (tc === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected tc", 0, 1);
      end else begin
        n = notes.pop_front();
        if (n.chk) chk("ticks", n.ticks, ticks);
        chk("running", n.run, running);
        chk("irq at tc", n.irq, irq);
      end
      ticks = 0;
    end
  end
  // Main sequence.
  initial begin
    {reset_in, clk_sel, mode, cmp_mode, period, compare} = {1'b1, 39'h0};
    {dead, tc_en, cmp_en, cap_en, sw_start, sw_stop, rd} = {8'h02, 6'b100000};
    void'($urandom(32'hb838));
    cyc(8);
    reset_in = 1'b0;
    cyc(2);
    for (int s = 0; s < 4; s++) begin
      clk_sel = s[1:0];
      period  = 16'($urandom_range(5, 1));
      notes.push_back('{1'b0, 17'h0, 1'b1, 1'b1});
      notes.push_back('{1'b1, {1'b0, period} + 17'h1, 1'b1, 1'b1});
      notes.push_back('{1'b1, {1'b0, period} + 17'h1, 1'b1, 1'b1});
      sw(0);
      wait_q();
      sw(1);
    end
    $display("test free run done");
    {mode, clk_sel, period} = {MODE_ONESHOT, 2'h0, 16'h0004};
    cyc(4);
    notes.push_back('{1'b0, 17'h0, 1'b0, 1'b1});
    sw(0);
    wait_q();
    cyc(60);
    chk("stopped", 0, running);
    notes.push_back('{1'b0, 17'h0, 1'b0, 1'b1});
    fabric_inst.pulse_pin(0);
    wait_q();
    $display("test one shot done");
    {mode, period} = {MODE_GATED, 16'h0014};
    cyc(4);
    sw(0);
    cyc(40);
    rd_cnt(v);
    chk("gated hold", period, v);
    fabric_inst.enable_out = 1'b1;
    cyc(40);
    fabric_inst.enable_out = 1'b0;
    cyc(8);
    rd_cnt(c1);
    chk("moved down", 1, c1 < period);
    cyc(30);
    rd_cnt(v);
    chk("held", c1, v);
    cap_en = 1'b1;
    i0 = irq_seen;
    fabric_inst.pulse_pin(2);
    cyc(6);
    chk("capture", c1, cap);
    chk("capture irq", i0 + 1, irq_seen);
    cap_en = 1'b0;
    fabric_inst.pulse_pin(1);
    cyc(6);
    rd_cnt(v);
    chk("reload", period, v);
    $display("test gated capture done");
    // The compare output has stayed low so far, since the count is never below zero.
    prev_c = 1'b0;
    for (int m = 0; m < 5; m++) begin
      for (int d = 0; d < 3; d++) begin
        cmp_mode = m[2:0];
        compare  = 16'(19 + d);
        case (m)
          0: exp_c = (d == 2);
          1: exp_c = (d >= 1);
          2: exp_c = (d == 1);
          3: exp_c = (d <= 1);
          default: exp_c = (d == 0);
        endcase
        // A change of compare result must first drop both outputs for the dead band.
        cyc(4);
        if (exp_c != prev_c) chk("dead band", 0, {cmp, cmp_n});
        prev_c = exp_c;
        cyc(56);
        chk("cmp", exp_c, cmp);
        chk("cmp_n", !exp_c, cmp_n);
      end
    end
    fabric_inst.kill_out = 1'b1;
    cyc(6);
    chk("kill pair", 0, {cmp, cmp_n});
    fabric_inst.kill_out = 1'b0;
    cyc(60);
    chk("after kill", 1, cmp_n);
    $display("test compare kill done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
